// [common/iap_pkg.sv]
// Purpose: Constants for the isolated ADC I/O port control block
// Assumes: Byte-wide I/O bus, 10-bit port address, one 20 MHz clock
// Notes:   Offsets are within the 16-location port block
package iap_pkg;
    localparam int         ADDR_W        = 10;
    localparam int         BASE_W        = 6;
    localparam int         RES_W         = 12;
    localparam int         CH_W          = 5;
    localparam int         GAIN_W        = 3;
    localparam logic [3:0] OFS_RES_LOW   = 4'h4;
    localparam logic [3:0] OFS_RES_HIGH  = 4'h5;
    localparam logic [3:0] OFS_GAIN      = 4'h9;
    localparam logic [3:0] OFS_CHANNEL   = 4'ha;
    localparam logic [3:0] OFS_TRIGGER   = 4'hc;
    localparam int         READY_BIT     = 4;
    localparam logic [4:0] RST_CHANNEL   = 5'h00;
    localparam logic [2:0] RST_GAIN      = 3'h0;
    localparam logic [4:0] RST_GAIN_MULT = 5'h01;
    localparam logic [11:0] RST_RESULT   = 12'h000;
    localparam logic       RST_FLAG      = 1'b1;
    localparam logic [7:0] UNUSED_READ   = 8'h00;
    // Conversion time of the converter, in ns, and its cycle count
    localparam int         CONV_TIME_NS  = 10000;
    localparam int         CLK_PERIOD_NS = 50;
    localparam int         CONV_CYCLES   =
        (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : iap_pkg

// [verilog/iap_gain_decode.sv]
// Purpose: Gain code to multiplier and range descriptor
// Assumes: Codes above 100 are unused by software
// Notes:   Unused codes fall back to gain 1
`timescale 1ns/1ps
module iap_gain_decode
    import iap_pkg::*;
(
    input  wire logic [2:0] gain_code,
    input  wire logic       span_strap,
    input  wire logic       polarity_strap,
    output logic      [4:0] gain_mult,
    output logic            range_valid
);
    always_comb begin
        unique case (gain_code)
            3'h0:    gain_mult = 5'h01;
            3'h1:    gain_mult = 5'h02;
            3'h2:    gain_mult = 5'h04;
            3'h3:    gain_mult = 5'h08;
            3'h4:    gain_mult = 5'h10;
            default: gain_mult = 5'h01;
        endcase
    end

    // 20V unipolar at gain 1 is an unused combination
    assign range_valid = !(span_strap && polarity_strap &&
                           gain_mult == 5'h01);
endmodule : iap_gain_decode

// [verilog/iap_port_ctrl.sv]
// Purpose: I/O port decode, result registers and converter control
// Assumes: Bus strobes are one-cycle pulses synchronous to core_clk
// Notes:   Converter start is a one-cycle pulse; done latches the data
`timescale 1ns/1ps
module iap_port_ctrl
    import iap_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic [9:0]  io_addr,
    input  wire logic [7:0]  io_wdata,
    input  wire logic        io_rd,
    input  wire logic        io_wr,
    input  wire logic [5:0]  base_switch,
    output logic      [7:0]  io_rdata,
    output logic             io_sel,
    input  wire logic        span_strap,
    input  wire logic        polarity_strap,
    output logic             conv_start,
    input  wire logic        conv_done,
    input  wire logic [11:0] conv_data,
    output logic      [4:0]  mux_channel,
    output logic      [2:0]  gain_code,
    output logic      [4:0]  gain_mult,
    output logic             range_valid,
    output logic             span_20v,
    output logic             unipolar
);
    logic [3:0]  offset;
    logic        hit;
    logic        rd_low;
    logic        rd_high;
    logic        wr_gain;
    logic        wr_chan;
    logic        wr_trig;
    logic [11:0] conversion_result_reg;
    logic        result_pending_flag_reg;
    logic [4:0]  channel_reg;
    logic [2:0]  gain_reg;
    logic        start_reg;
    logic [7:0]  rdata_reg;

    assign offset  = io_addr[3:0];
    assign hit     = (io_addr[9:4] == base_switch);
    assign io_sel  = hit && (io_rd || io_wr);
    assign rd_low  = hit && io_rd && offset == OFS_RES_LOW;
    assign rd_high = hit && io_rd && offset == OFS_RES_HIGH;
    assign wr_gain = hit && io_wr && offset == OFS_GAIN;
    assign wr_chan = hit && io_wr && offset == OFS_CHANNEL;
    assign wr_trig = hit && io_wr && offset == OFS_TRIGGER;

    // Channel register drives the multiplexer straight away
    always_ff @(posedge core_clk) begin
        if (rst) begin
            channel_reg <= RST_CHANNEL;
        end else if (wr_chan) begin
            channel_reg <= io_wdata[4:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            gain_reg <= RST_GAIN;
        end else if (wr_gain) begin
            gain_reg <= io_wdata[2:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            start_reg <= 1'b0;
        end else begin
            start_reg <= wr_trig;
        end
    end

    // Only converter completion loads the result; bus writes never do
    always_ff @(posedge core_clk) begin
        if (rst) begin
            conversion_result_reg <= RST_RESULT;
        end else if (conv_done) begin
            conversion_result_reg <= conv_data;
        end
    end

    // Completion wins over a low-byte read in the same cycle
    always_ff @(posedge core_clk) begin
        if (rst) begin
            result_pending_flag_reg <= RST_FLAG;
        end else if (conv_done) begin
            result_pending_flag_reg <= 1'b0;
        end else if (rd_low) begin
            result_pending_flag_reg <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata_reg <= UNUSED_READ;
        end else if (rd_low) begin
            rdata_reg <= conversion_result_reg[7:0];
        end else if (rd_high) begin
            rdata_reg <= {3'h0, result_pending_flag_reg,
                          conversion_result_reg[11:8]};
        end else if (hit && io_rd) begin
            rdata_reg <= UNUSED_READ;
        end
    end

    iap_gain_decode u_gain (
        .gain_code      (gain_reg),
        .span_strap     (span_strap),
        .polarity_strap (polarity_strap),
        .gain_mult      (gain_mult),
        .range_valid    (range_valid)
    );

    assign io_rdata    = rdata_reg;
    assign conv_start  = start_reg;
    assign mux_channel = channel_reg;
    assign gain_code   = gain_reg;
    assign span_20v    = span_strap;
    assign unipolar    = polarity_strap;

    // Host reads data only after flag clears; no guard needed here

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_trig;
        wr_trig;
    endsequence
    sequence s_start;
        conv_start;
    endsequence
    sequence s_low_read;
        rd_low && !conv_done;
    endsequence
    sequence s_pending;
        result_pending_flag_reg;
    endsequence

    trig_start_a: assert property (s_trig |=> s_start)
        else $error("trigger write did not start conversion");
    start_only_a: assert property (
        conv_start |-> $past(wr_trig))
        else $error("conversion started without trigger");
    chan_write_a: assert property (wr_chan |=>
        mux_channel == $past(io_wdata[4:0]))
        else $error("channel not switched");
    chan_hold_a: assert property (
        !wr_chan |=> $stable(mux_channel))
        else $error("channel changed without write");
    gain_write_a: assert property (wr_gain |=>
        gain_code == $past(io_wdata[2:0]))
        else $error("gain not written");
    gain_hold_a: assert property (
        !wr_gain |=> $stable(gain_code))
        else $error("gain changed without write");
    done_clear_a: assert property (conv_done |=>
        !result_pending_flag_reg)
        else $error("ready flag not cleared on completion");
    low_set_a: assert property (s_low_read |=> s_pending)
        else $error("low byte read did not set flag");
    flag_hold_a: assert property (
        !conv_done && !rd_low |=> $stable(result_pending_flag_reg))
        else $error("ready flag changed without cause");
    res_hold_a: assert property (!conv_done |=>
        $stable(conversion_result_reg))
        else $error("result changed without completion");
    res_load_a: assert property (conv_done |=>
        conversion_result_reg == $past(conv_data))
        else $error("completed result not loaded");
    high_fmt_a: assert property (rd_high |=>
        io_rdata == {3'h0, $past(result_pending_flag_reg),
                     $past(conversion_result_reg[11:8])})
        else $error("high byte format wrong");
    low_fmt_a: assert property (rd_low |=>
        io_rdata == $past(conversion_result_reg[7:0]))
        else $error("low byte data wrong");
    unused_rd_a: assert property (
        hit && io_rd && !rd_low && !rd_high |=> io_rdata == UNUSED_READ)
        else $error("unused location read not zero");
    rdata_hold_a: assert property (
        !io_rd |=> $stable(io_rdata))
        else $error("read data changed without read");
    gain_map_a: assert property (gain_code == 3'h4 |->
        gain_mult == 5'h10)
        else $error("gain 16 decode wrong");
    gain_low_a: assert property (gain_code < 3'h4 |->
        gain_mult == (5'h01 << gain_code))
        else $error("gain 1 to 8 decode wrong");
    range_bad_a: assert property (
        span_strap && polarity_strap && gain_code == 3'h0 |-> !range_valid)
        else $error("unused range reported valid");
    range_bip_a: assert property (
        !polarity_strap |-> range_valid)
        else $error("bipolar range reported invalid");
    decode_a: assert property (
        io_rd && io_addr[9:4] != base_switch |=> $stable(io_rdata))
        else $error("read outside base block answered");
endmodule : iap_port_ctrl

// [dv/iap_conv_model.sv]
// Purpose: Converter and multiplexer model beside the port block
// Assumes: Start is a one-cycle pulse
// Notes:   Result encodes gain and channel
`timescale 1ns/1ps
module iap_conv_model
    import iap_pkg::*;
#(
    parameter int DLY = 8
)
(
    input  wire logic        core_clk,
    input  wire logic        conv_start,
    input  wire logic [4:0]  mux_channel,
    input  wire logic [2:0]  gain_code,
    output logic             conv_done,
    output logic      [11:0] conv_data
);
    int cnt = 0;
    initial conv_done = 1'b0;
    initial conv_data = 12'h000;
    always @(posedge core_clk) begin
        cnt <= conv_start ? DLY : (cnt > 0 ? cnt - 1 : 0);
        conv_done <= (cnt == 1);
        // Data only valid with done, scrambled otherwise
        conv_data <= (cnt == 1) ? {gain_code, mux_channel, 4'ha}
                                : ~conv_data;
    end
endmodule : iap_conv_model

// [dv/testbench.sv]
// Purpose: Self-checking bench for the port block
// Assumes: Bench acts as host, model as converter
// Notes:   Block placed at base 0x220
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
    err_total++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module testbench
    import iap_pkg::*;
;
    localparam logic [5:0]  B = 6'h22;
    localparam logic [11:0] E = {3'h3, 5'h13, 4'ha};
    logic core_clk = 0, rst = 1, io_rd = 0, io_wr = 0;
    logic span_strap = 0, polarity_strap = 0, conv_start, conv_done;
    logic io_sel, range_valid, span_20v, unipolar;
    logic [9:0] io_addr = '0;
    logic [7:0] io_wdata = '0, io_rdata;
    logic [5:0] base_switch = B;
    logic [11:0] conv_data;
    logic [4:0] mux_channel, gain_mult;
    logic [2:0] gain_code;
    int err_total = 0, n_tests = 0, cyc = 0;
    iap_port_ctrl DUT (.core_clk, .rst, .io_addr, .io_wdata, .io_rd,
        .io_wr, .base_switch, .io_rdata, .io_sel, .span_strap,
        .polarity_strap, .conv_start, .conv_done, .conv_data,
        .mux_channel, .gain_code, .gain_mult, .range_valid, .span_20v,
        .unipolar);
    iap_conv_model #(.DLY(8)) conv (.core_clk, .conv_start,
        .mux_channel, .gain_code, .conv_done, .conv_data);
    initial forever #25 core_clk = ~core_clk;
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            end_sim();
        end
    end
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge core_clk);
        io_addr  <= a;
        io_wdata <= d;
        io_wr    <= 1'b1;
        @(posedge core_clk);
        io_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [9:0] a, output logic [7:0] d);
        @(posedge core_clk);
        io_addr <= a;
        io_rd   <= 1'b1;
        @(posedge core_clk);
        io_rd <= 1'b0;
        #1;
        d = io_rdata;
    endtask : rd
    task automatic t_reset();
        logic [7:0] d;
        rd({B, OFS_RES_HIGH}, d);
        `CHK("rst_high", 8'h10, d)
        rd({B, OFS_RES_LOW}, d);
        `CHK("rst_low", RST_RESULT[7:0], d)
        $display("t_reset done");
    endtask : t_reset
    task automatic t_regs();
        logic [4:0] ch [3] = '{5'h00, 5'h1f, 5'h0a};
        for (int i = 0; i < 5; i++) begin
            wr({B, OFS_GAIN}, 8'hf8 | 8'(i));
            `CHK("gain", 3'(i), gain_code)
            `CHK("mult", 5'(1 << i), gain_mult)
        end
        wr({B, OFS_GAIN}, 8'h07);
        `CHK("mult_unused", 5'h01, gain_mult)
        foreach (ch[i]) begin
            wr({B, OFS_CHANNEL}, {3'h7, ch[i]});
            `CHK("chan", ch[i], mux_channel)
        end
        wr({B, OFS_GAIN}, 8'h00);
        for (int s = 0; s < 4; s++) begin
            @(posedge core_clk);
            span_strap     <= s[1];
            polarity_strap <= s[0];
            #1;
            `CHK("span", s[1], span_20v)
            `CHK("pol", s[0], unipolar)
            `CHK("range", 1'(s != 3), range_valid)
        end
        $display("t_regs done");
    endtask : t_regs
    task automatic t_conv();
        logic [7:0] d;
        int n;
        wr({B, OFS_CHANNEL}, 8'h13);
        wr({B, OFS_GAIN}, 8'h03);
        wr({B, OFS_TRIGGER}, 8'h5c);
        `CHK("start", 1'b1, conv_start)
        d = 8'h10;
        for (n = 0; n < 40 && d[4]; n++)
            rd({B, OFS_RES_HIGH}, d);
        `CHK("pending", 1'b1, n > 1)
        `CHK("high", {4'h0, E[11:8]}, d)
        rd({B, OFS_RES_LOW}, d);
        `CHK("low", E[7:0], d)
        rd({B, OFS_RES_HIGH}, d);
        `CHK("flag", {4'h1, E[11:8]}, d)
        $display("t_conv done");
    endtask : t_conv
    task automatic t_refuse();
        logic [7:0] d;
        wr({B, OFS_RES_LOW}, 8'hff);
        wr({B, OFS_RES_HIGH}, 8'he0);
        wr({B, 4'h0}, 8'hff);
        wr({B ^ 6'h01, OFS_CHANNEL}, 8'h07);
        wr({B ^ 6'h01, OFS_TRIGGER}, 8'h00);
        `CHK("no_start", 1'b0, conv_start)
        `CHK("chan", 5'h13, mux_channel)
        rd({B, OFS_GAIN}, d);
        `CHK("wo_read", UNUSED_READ, d)
        rd({B, OFS_RES_HIGH}, d);
        `CHK("ro_high", {4'h1, E[11:8]}, d)
        rd({B, OFS_RES_LOW}, d);
        `CHK("ro_low", E[7:0], d)
        @(posedge core_clk);
        io_addr <= {B ^ 6'h01, OFS_RES_LOW};
        io_rd   <= 1'b1;
        #1;
        `CHK("sel_out", 1'b0, io_sel)
        @(posedge core_clk);
        io_addr <= {B, 4'hf};
        #1;
        `CHK("rd_out", E[7:0], io_rdata)
        `CHK("sel_in", 1'b1, io_sel)
        @(posedge core_clk);
        io_rd <= 1'b0;
        #1;
        `CHK("rd_unused", UNUSED_READ, io_rdata)
        $display("t_refuse done");
    endtask : t_refuse
    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_regs();
        t_conv();
        t_refuse();
        end_sim();
    end
endmodule : testbench
